/* File: dv/ioxp_ctrl_model.sv */
`timescale 1ns/1ps
// ----------------
// Bus controller model
// ----------------
module ioxp_ctrl_model (
	input wire logic core_clk,
	input wire logic sda_out,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic sda_drv = 1'b1;
	logic scl_drv = 1'b1;
	assign scl = scl_drv;
	assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic bit_x(input logic b, output logic r);
		sda_drv = b;
		tick(10);
		scl_drv = 1'b1;
		tick(10);
		r = sda;
		tick(10);
		scl_drv = 1'b0;
		tick(10);
	endtask
	task automatic start;
		sda_drv = 1'b1;
		tick(10);
		scl_drv = 1'b1;
		tick(10);
		sda_drv = 1'b0;
		tick(10);
		scl_drv = 1'b0;
		tick(10);
	endtask
	task automatic stop;
		sda_drv = 1'b0;
		tick(10);
		scl_drv = 1'b1;
		tick(10);
		sda_drv = 1'b1;
		tick(10);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
		output logic ackd);
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], rx[i]);
		end
		bit_x(ack, ackd);
	endtask
endmodule // ioxp_ctrl_model

/* File: dv/tb_ioxp_top.sv */
`timescale 1ns/1ps
// ----------------
// Bench top
// ----------------
module tb_ioxp_top;
	import ioxp_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] strap = 3'h5;
	logic [7:0] pins_in = 8'h00;
	logic [7:0] pins_out;
	logic [7:0] pins_oe;
	logic scl;
	logic sda;
	logic sda_out;
	logic sda_oe;
	logic alert_n_out;
	logic alert_n_oe;
	logic alert_n;
	logic [7:0] rd;
	logic ackd;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #2 core_clk = ~core_clk;
	assign alert_n = alert_n_oe ? alert_n_out : 1'b1;
	ioxp_top ioxp_top_inst (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .strap_addr_bit2(strap[2]),
		.strap_addr_bit1(strap[1]), .strap_addr_bit0(strap[0]), .gp_port_pins_in(pins_in),
		.gp_port_pins_out(pins_out), .gp_port_pins_oe(pins_oe), .alert_n_out(alert_n_out),
		.alert_n_oe(alert_n_oe));
	ioxp_ctrl_model ioxp_ctrl_model_inst (.core_clk(core_clk), .sda_out(sda_out),
		.sda_oe(sda_oe), .scl(scl), .sda(sda));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic send(input logic [7:0] b);
		ioxp_ctrl_model_inst.xfer(b, 1'b1, rd, ackd);
		check({7'h00, ackd}, 8'h00);
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
		ioxp_ctrl_model_inst.start();
		send({4'h4, strap, 1'b0});
		send(cmd);
		send(d0);
		send(d1);
		ioxp_ctrl_model_inst.stop();
	endtask
	task automatic rd_reg(input logic [7:0] cmd, input logic [7:0] exp);
		ioxp_ctrl_model_inst.start();
		send({4'h4, strap, 1'b0});
		send(cmd);
		ioxp_ctrl_model_inst.start();
		send({4'h4, strap, 1'b1});
		ioxp_ctrl_model_inst.xfer(8'hFF, 1'b0, rd, ackd);
		check(rd, exp);
		ioxp_ctrl_model_inst.xfer(8'hFF, 1'b1, rd, ackd);
		check(rd, exp);
		ioxp_ctrl_model_inst.stop();
	endtask
	task automatic rd_cur(input logic [7:0] exp);
		ioxp_ctrl_model_inst.start();
		send({4'h4, strap, 1'b1});
		ioxp_ctrl_model_inst.xfer(8'hFF, 1'b0, rd, ackd);
		check(rd, exp);
		ioxp_ctrl_model_inst.xfer(8'hFF, 1'b1, rd, ackd);
		check(rd, exp);
		ioxp_ctrl_model_inst.stop();
	endtask
	task automatic pin(input logic [7:0] v, input logic exp_n);
		pins_in = v;
		repeat (10) @(negedge core_clk);
		check({7'h00, alert_n}, {7'h00, exp_n});
	endtask
	task automatic done(input string name);
		$display("test %s finished, failures so far %0d", name, failures);
	endtask
	task automatic summarize;
		$display("checked %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			failures++;
			summarize();
		end
	end
	initial begin
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		check({7'h00, alert_n}, 8'h01);
		check(pins_oe, 8'h00);
		check(pins_out, 8'hFF);
		rd_reg(8'h01, 8'hFF);
		rd_reg(8'h02, 8'h00);
		rd_reg(8'h03, 8'hFF);
		done("defaults");
		wr(8'h01, 8'h5A, 8'hA5);
		wr(8'h03, 8'hFF, 8'h0F);
		check(pins_out, 8'hA5);
		check(pins_oe, 8'hF0);
		rd_reg(8'h03, 8'h0F);
		done("write");
		pin(8'h80, 1'b1);
		pin(8'h81, 1'b0);
		pin(8'h80, 1'b1);
		pin(8'h01, 1'b0);
		ioxp_ctrl_model_inst.start();
		ioxp_ctrl_model_inst.xfer({4'h4, ~strap, 1'b0}, 1'b1, rd, ackd);
		check({7'h00, ackd}, 8'h01);
		ioxp_ctrl_model_inst.stop();
		check({7'h00, alert_n}, 8'h00);
		rd_reg(8'h00, 8'h01);
		check({7'h00, alert_n}, 8'h01);
		pin(8'h00, 1'b0);
		done("alert");
		wr(8'h00, 8'h12, 8'h34);
		check(pins_out, 8'hA5);
		check(pins_oe, 8'hF0);
		rd_cur(8'h00);
		check({7'h00, alert_n}, 8'h01);
		wr(8'h02, 8'h0F, 8'h03);
		rd_reg(8'h00, 8'h03);
		pin(8'h02, 1'b0);
		done("registers");
		rst = 1'b1;
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		check({7'h00, alert_n}, 8'h01);
		check(pins_out, 8'hFF);
		check(pins_oe, 8'h00);
		rd_cur(8'h02);
		check({7'h00, alert_n}, 8'h01);
		rd_reg(8'h02, 8'h00);
		done("reset");
		summarize();
	end
endmodule // tb_ioxp_top

/* File: hdl/ioxp_bus_if.sv */
`timescale 1ns/1ps
interface ioxp_bus_if;
	logic scl_rise;
	logic scl_fall;
	logic scl_lvl;
	logic sda_lvl;
	logic start;
	logic stop;
	modport front (output scl_rise, output scl_fall, output scl_lvl, output sda_lvl,
		output start, output stop);
	modport core (input scl_rise, input scl_fall, input scl_lvl, input sda_lvl,
		input start, input stop);
endinterface

/* File: hdl/ioxp_cfg.svh */
`ifndef IOXP_CFG_SVH
`define IOXP_CFG_SVH
`define IOXP_ADDR_FIXED 4'h4
`define IOXP_SEL_INPUT 2'h0
`define IOXP_SEL_OUTPUT 2'h1
`define IOXP_SEL_POLAR 2'h2
`define IOXP_SEL_DIR 2'h3
`define IOXP_OUT_RST 8'hFF
`define IOXP_POL_RST 8'h00
`define IOXP_DIR_RST 8'hFF
`define IOXP_CMD_RST 8'h00
`endif

/* File: hdl/ioxp_line_sync.sv */
`timescale 1ns/1ps
module ioxp_line_sync
	import ioxp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	ioxp_bus_if.front bus
);
	// ----------------------------------------
	// Three-flop sync then edge detection
	// ----------------------------------------
	logic [1:0] scl_s1_q, scl_s1_d;
	logic [1:0] scl_s2_q, scl_s2_d;
	logic [1:0] sda_s1_q, sda_s1_d;
	logic [1:0] sda_s2_q, sda_s2_d;

	always_comb begin
		scl_s1_d = {scl_s1_q[0], scl_in};
		sda_s1_d = {sda_s1_q[0], sda_in};
		scl_s2_d = {scl_s2_q[0], scl_s1_q[1]};
		sda_s2_d = {sda_s2_q[0], sda_s1_q[1]};
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_s1_q <= 2'h3;
			sda_s1_q <= 2'h3;
			scl_s2_q <= 2'h3;
			sda_s2_q <= 2'h3;
		end else begin
			scl_s1_q <= scl_s1_d;
			sda_s1_q <= sda_s1_d;
			scl_s2_q <= scl_s2_d;
			sda_s2_q <= sda_s2_d;
		end
	end

	assign bus.scl_lvl = scl_s2_q[0];
	assign bus.sda_lvl = sda_s2_q[0];
	assign bus.scl_rise = scl_s2_q[0] & ~scl_s2_q[1];
	assign bus.scl_fall = ~scl_s2_q[0] & scl_s2_q[1];
	assign bus.start = scl_s2_q[0] & scl_s2_q[1] & ~sda_s2_q[0] & sda_s2_q[1];
	assign bus.stop = scl_s2_q[0] & scl_s2_q[1] & sda_s2_q[0] & ~sda_s2_q[1];
endmodule // ioxp_line_sync

/* File: hdl/ioxp_pkg.sv */
package ioxp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR_BYTE,
		ST_WR_ACK,
		ST_RD_BYTE,
		ST_RD_ACK
	} ioxp_state_t;
endpackage

/* File: hdl/ioxp_top.sv */
`timescale 1ns/1ps
`include "ioxp_cfg.svh"
module ioxp_top
	import ioxp_pkg::*;
#(
	parameter int PORT_W = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic strap_addr_bit2,
	input wire logic strap_addr_bit1,
	input wire logic strap_addr_bit0,
	input wire logic [PORT_W-1:0] gp_port_pins_in,
	output logic [PORT_W-1:0] gp_port_pins_out,
	output logic [PORT_W-1:0] gp_port_pins_oe,
	output logic alert_n_out,
	output logic alert_n_oe
);
	// ----------------------------------------
	// Line front end
	// ----------------------------------------
	ioxp_bus_if bus ();
	ioxp_line_sync ioxp_line_sync_inst (
		.core_clk(core_clk),
		.rst(rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.bus(bus)
	);

	// ----------------------------------------
	// Pin and strap sync
	// ----------------------------------------
	logic [PORT_W-1:0] pin_s1_q, pin_s2_q;
	logic [2:0] strap_s1_q, strap_s2_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			strap_s1_q <= 3'h0;
			strap_s2_q <= 3'h0;
		end else begin
			pin_s1_q <= gp_port_pins_in;
			pin_s2_q <= pin_s1_q;
			strap_s1_q <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
			strap_s2_q <= strap_s1_q;
		end
	end

	// ----------------------------------------
	// Serial state machine and registers
	// ----------------------------------------
	ioxp_state_t state_q, state_d;
	logic [7:0] shift_q, shift_d;
	logic [3:0] bit_q, bit_d;
	logic rw_q, rw_d;
	logic cmd_pend_q, cmd_pend_d;
	logic [7:0] cmd_q, cmd_d;
	logic [PORT_W-1:0] out_q, out_d, pol_q, pol_d, dir_q, dir_d;
	logic [PORT_W-1:0] cap_q, cap_d;
	logic sda_drv_q, sda_drv_d;
	logic alert_clr;
	logic [PORT_W-1:0] rd_val;
	logic rd_acked_q, rd_acked_d;

	always_comb begin
		case (cmd_q[1:0])
			`IOXP_SEL_INPUT: rd_val = pin_s2_q ^ pol_q;
			`IOXP_SEL_OUTPUT: rd_val = out_q;
			`IOXP_SEL_POLAR: rd_val = pol_q;
			default: rd_val = dir_q;
		endcase
	end

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		bit_d = bit_q;
		rw_d = rw_q;
		cmd_pend_d = cmd_pend_q;
		cmd_d = cmd_q;
		out_d = out_q;
		pol_d = pol_q;
		dir_d = dir_q;
		sda_drv_d = sda_drv_q;
		rd_acked_d = rd_acked_q;
		alert_clr = 1'b0;
		if (bus.stop) begin
			state_d = ST_IDLE;
			sda_drv_d = 1'b0;
		end else if (bus.start) begin
			state_d = ST_ADDR;
			bit_d = 4'h0;
			sda_drv_d = 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
				end
				ST_ADDR, ST_WR_BYTE: begin
					if (bus.scl_rise) begin
						shift_d = {shift_q[6:0], bus.sda_lvl};
						bit_d = bit_q + 4'h1;
					end else if (bus.scl_fall && bit_q == 4'h8) begin
						bit_d = 4'h0;
						if (state_q == ST_ADDR) begin
							if (shift_q[7:1] == {`IOXP_ADDR_FIXED, strap_s2_q}) begin
								state_d = ST_ADDR_ACK;
								rw_d = shift_q[0];
								cmd_pend_d = ~shift_q[0];
								sda_drv_d = 1'b1;
							end else begin
								state_d = ST_IDLE;
							end
						end else begin
							state_d = ST_WR_ACK;
							sda_drv_d = 1'b1;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (bus.scl_fall) begin
						sda_drv_d = 1'b0;
						if (rw_q) begin
							state_d = ST_RD_BYTE;
							shift_d = rd_val;
							sda_drv_d = ~rd_val[7];
							bit_d = 4'h1;
						end else begin
							state_d = ST_WR_BYTE;
						end
					end
				end
				ST_WR_ACK: begin
					if (bus.scl_rise) begin
						if (cmd_pend_q) begin
							cmd_d = shift_q;
							cmd_pend_d = 1'b0;
						end else begin
							case (cmd_q[1:0])
								`IOXP_SEL_OUTPUT: out_d = shift_q;
								`IOXP_SEL_POLAR: pol_d = shift_q;
								`IOXP_SEL_DIR: dir_d = shift_q;
								default: ;
							endcase
						end
					end else if (bus.scl_fall) begin
						sda_drv_d = 1'b0;
						state_d = ST_WR_BYTE;
					end
				end
				ST_RD_BYTE: begin
					if (bus.scl_fall) begin
						if (bit_q == 4'h8) begin
							sda_drv_d = 1'b0;
							state_d = ST_RD_ACK;
						end else begin
							sda_drv_d = ~shift_q[7 - bit_q[2:0]];
							bit_d = bit_q + 4'h1;
						end
					end
				end
				ST_RD_ACK: begin
					if (bus.scl_rise) begin
						rd_acked_d = ~bus.sda_lvl;
						if (cmd_q[1:0] == `IOXP_SEL_INPUT) alert_clr = 1'b1;
					end else if (bus.scl_fall) begin
						if (rd_acked_q) begin
							state_d = ST_RD_BYTE;
							shift_d = rd_val;
							sda_drv_d = ~rd_val[7];
							bit_d = 4'h1;
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
				default: state_d = ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Change detection
	// ----------------------------------------
	logic [PORT_W-1:0] diff;
	logic alert_q, alert_d;
	always_comb begin
		diff = (pin_s2_q ^ cap_q) & dir_q;
		cap_d = alert_clr ? pin_s2_q : cap_q;
		alert_d = (|diff) & ~alert_clr;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			bit_q <= 4'h0;
			rw_q <= 1'b0;
			cmd_pend_q <= 1'b0;
			cmd_q <= `IOXP_CMD_RST;
			out_q <= `IOXP_OUT_RST;
			pol_q <= `IOXP_POL_RST;
			dir_q <= `IOXP_DIR_RST;
			cap_q <= '0;
			sda_drv_q <= 1'b0;
			rd_acked_q <= 1'b0;
			alert_q <= 1'b0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			bit_q <= bit_d;
			rw_q <= rw_d;
			cmd_pend_q <= cmd_pend_d;
			cmd_q <= cmd_d;
			out_q <= out_d;
			pol_q <= pol_d;
			dir_q <= dir_d;
			cap_q <= cap_d;
			sda_drv_q <= sda_drv_d;
			rd_acked_q <= rd_acked_d;
			alert_q <= alert_d;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = sda_drv_q;
	assign alert_n_out = 1'b0;
	assign alert_n_oe = alert_q;
	assign gp_port_pins_out = out_q;
	assign gp_port_pins_oe = ~dir_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_alert_pull_only: assert property (@(posedge core_clk) disable iff (rst)
		alert_n_out == 1'b0) else $error("alert drives high");
	a_alert_on_change: assert property (@(posedge core_clk) disable iff (rst)
		(|((pin_s2_q ^ cap_q) & dir_q)) && !alert_clr |=> alert_n_oe)
		else $error("change not flagged");
	a_alert_revert: assert property (@(posedge core_clk) disable iff (rst)
		((pin_s2_q ^ cap_q) & dir_q) == '0 |=> !alert_n_oe)
		else $error("alert not withdrawn");
	a_alert_read_clr: assert property (@(posedge core_clk) disable iff (rst)
		alert_clr |=> !alert_n_oe && cap_q == $past(pin_s2_q))
		else $error("read did not clear");
	a_out_no_alert: assert property (@(posedge core_clk) disable iff (rst)
		!alert_n_oe && $stable(dir_q) && $stable(pin_s2_q & dir_q) |=> !alert_n_oe)
		else $error("output pin raised alert");
	a_stop_idles: assert property (@(posedge core_clk) disable iff (rst)
		bus.stop |=> state_q == ST_IDLE && !sda_oe) else $error("stop ignored");
	a_cmd_kept: assert property (@(posedge core_clk) disable iff (rst)
		bus.start |=> $stable(cmd_q)) else $error("selection lost");
	a_dir_drive: assert property (@(posedge core_clk) disable iff (rst)
		gp_port_pins_oe == ~dir_q && gp_port_pins_out == out_q)
		else $error("pin drive wrong");
endmodule // ioxp_top
